// ==== rtl/lpi_pkg.sv ====
// Package for the line interface power and timer-event register group
`default_nettype none

package lpi_pkg;

  // ==========================================================================
  // Register offsets (register index on the serial control port)
  localparam logic [7:0] ADDR_HYBRID_GAIN = 8'h0B;
  localparam logic [7:0] ADDR_PWR_OVERRIDE = 8'h0E;
  localparam logic [7:0] ADDR_CONV_PWR = 8'h0F;
  localparam logic [7:0] ADDR_TIMER_PEND = 8'h12;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_HYBRID_GAIN = 8'h00;
  localparam logic [7:0] RST_PWR_OVERRIDE = 8'h10;
  localparam logic [7:0] RST_CONV_PWR = 8'h00;
  localparam logic [7:0] RST_TIMER_PEND = 8'h00;

  // ==========================================================================
  // Writable bit masks; all other bits read zero
  localparam logic [7:0] MASK_HYBRID_GAIN = 8'h77;
  localparam logic [7:0] MASK_PWR_OVERRIDE = 8'h3B;
  localparam logic [7:0] MASK_CONV_PWR = 8'h3F;
  localparam logic [7:0] MASK_TIMER_PEND = 8'hFF;

  // ==========================================================================
  // Field positions
  localparam int HYB_METER_LSB = 4;
  localparam int HYB_AUDIO_LSB = 0;
  localparam int HYB_W = 3;
  localparam int PO_METER_DAC_ON = 5;
  localparam int PO_CONV_OFF = 4;
  localparam int PO_MON_ADC_OFF = 3;
  localparam int PO_BIAS_OFF = 1;
  localparam int PO_LINE_OFF = 0;
  localparam int CP_ADC_MAN = 5;
  localparam int CP_ADC_ON = 4;
  localparam int CP_DAC_MAN = 3;
  localparam int CP_DAC_ON = 2;
  localparam int CP_GM_MAN = 1;
  localparam int CP_GM_ON = 0;

  // Pending bit positions
  localparam int EV_METER_INACTIVE = 7;
  localparam int EV_METER_ACTIVE = 6;
  localparam int EV_RING_INACTIVE = 5;
  localparam int EV_RING_ACTIVE = 4;
  localparam int EV_OSC2_INACTIVE = 3;
  localparam int EV_OSC2_ACTIVE = 2;
  localparam int EV_OSC1_INACTIVE = 1;
  localparam int EV_OSC1_ACTIVE = 0;

  // ==========================================================================
  // Hybrid gain codes
  localparam logic [2:0] HYB_CODE_RESERVED = 3'h6;
  localparam logic [2:0] HYB_CODE_OFF = 3'h7;

  // Automatic power requests from the power manager
  typedef struct packed {
    logic meter_dac;
    logic converter;
    logic monitor_adc;
    logic bias;
    logic line_drive;
    logic adc;
    logic dac;
    logic gm_amp;
  } lpi_pwr_s;

endpackage : lpi_pkg

`default_nettype wire

// ==== rtl/lpi_regs.sv ====
// Register group: hybrid gain, power overrides and timer-event pending flags
//
// Overview of operation
// RULE1: Two 3-bit hybrid gain fields, bits 6:4 meter and 2:0 audio; 111 is off.
// RULE2: Meter DAC automatic when force-on bit 5 is 0, forced on when 1.
// RULE3: Converter automatic when force-off bit 4 is 0, forced off when 1.
// RULE4: Monitor ADC automatic when force-off bit 3 is 0, forced off when 1.
// RULE5: Bias circuitry automatic when force-off bit 1 is 0, forced off when 1.
// RULE6: Line drive automatic when force-off bit 0 is 0, forced off when 1.
// RULE7: ADC manual select 1 makes ADC on bit set power, 1 on.
// RULE8: ADC manual select 0 ignores ADC on bit, uses automatic control.
// RULE9: DAC automatic when manual bit 0, else follows DAC on bit.
// RULE10: Gm amplifier automatic when manual bit 0, else follows its on bit.
// RULE11: Writing 1 to a pending bit clears it; host clears serviced events.
// RULE12: Pending bit reads 1 while pending, 0 otherwise.
// RULE13: Meter inactive event in bit 7, meter active event in bit 6.
// RULE14: Ring inactive event in bit 5, ring active event in bit 4.
// RULE15: Oscillator 2 inactive event in bit 3, active event in bit 2.
// RULE16: Oscillator 1 inactive event in bit 1, active event in bit 0.
// RULE17: Event reaches interrupt output only when its enable bit is 1.
// RULE18: Writing 0 leaves pending bit; event in clear cycle keeps it set.
// RULE19: Hybrid code 110 is reserved; unused bits read zero, ignore writes.
// RULE20: Single-cycle event pulse sets pending bit until host clears it.
`default_nettype none

module lpi_regs #(
  parameter int NUM_EVENTS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_EVENTS-1:0] timer_event,
  input wire logic [NUM_EVENTS-1:0] timer_irq_en,
  output logic timer_irq,
  input wire lpi_pkg::lpi_pwr_s auto_pwr,
  output lpi_pkg::lpi_pwr_s pwr_on,
  output logic [2:0] meter_hybrid_gain,
  output logic [2:0] audio_hybrid_gain,
  output logic meter_hybrid_off,
  output logic audio_hybrid_off
);

  // ==========================================================================
  // Register storage
  logic [7:0] hybrid_gain_control_reg;
  logic [7:0] power_override_control_reg;
  logic [7:0] converter_power_control_reg;
  logic [NUM_EVENTS-1:0] timer_event_pending_reg;
  logic [NUM_EVENTS-1:0] timer_event_pending_next;
  logic [2:0] meter_gain_next;
  logic [2:0] audio_gain_next;
  lpi_pkg::lpi_pwr_s pwr_next;

  logic wr_hyb;
  logic wr_po;
  logic wr_cp;
  logic wr_pend;

  assign wr_hyb = reg_wr && (reg_addr == lpi_pkg::ADDR_HYBRID_GAIN);
  assign wr_po = reg_wr && (reg_addr == lpi_pkg::ADDR_PWR_OVERRIDE);
  assign wr_cp = reg_wr && (reg_addr == lpi_pkg::ADDR_CONV_PWR);
  assign wr_pend = reg_wr && (reg_addr == lpi_pkg::ADDR_TIMER_PEND);

  // ==========================================================================
  // Hybrid gain: a reserved code in a field keeps that field's old value
  always_comb begin
    meter_gain_next = hybrid_gain_control_reg[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W];
    audio_gain_next = hybrid_gain_control_reg[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W];
    if (reg_wdata[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W] != lpi_pkg::HYB_CODE_RESERVED) begin
      meter_gain_next = reg_wdata[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W]; // [RULE19]
    end
    if (reg_wdata[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W] != lpi_pkg::HYB_CODE_RESERVED) begin
      audio_gain_next = reg_wdata[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W]; // [RULE19]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hybrid_gain_control_reg <= lpi_pkg::RST_HYBRID_GAIN;
    end else if (wr_hyb) begin
      hybrid_gain_control_reg <= {1'b0, meter_gain_next, 1'b0, audio_gain_next}; // [RULE1]
    end
  end

  // ==========================================================================
  // Power override registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_override_control_reg <= lpi_pkg::RST_PWR_OVERRIDE;
    end else if (wr_po) begin
      power_override_control_reg <= reg_wdata & lpi_pkg::MASK_PWR_OVERRIDE; // [RULE19]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converter_power_control_reg <= lpi_pkg::RST_CONV_PWR;
    end else if (wr_cp) begin
      converter_power_control_reg <= reg_wdata & lpi_pkg::MASK_CONV_PWR; // [RULE19]
    end
  end

  // ==========================================================================
  // Pending flags: set wins over a clearing write in the same cycle
  // Bit order of timer_event matches the register, so no remap is needed.
  always_comb begin
    timer_event_pending_next = timer_event_pending_reg;
    if (wr_pend) begin
      timer_event_pending_next = timer_event_pending_reg & ~reg_wdata[NUM_EVENTS-1:0]; // [RULE11] [RULE18]
    end
    timer_event_pending_next = timer_event_pending_next | timer_event; // [RULE18] [RULE20]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_event_pending_reg <= lpi_pkg::RST_TIMER_PEND[NUM_EVENTS-1:0];
    end else begin
      timer_event_pending_reg <= timer_event_pending_next; // [RULE13] [RULE14] [RULE15] [RULE16]
    end
  end

  // Computed from the next state so the line tracks the flags with no extra lag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(timer_event_pending_next & timer_irq_en); // [RULE17]
    end
  end

  // ==========================================================================
  // Register read port: data stands from the edge after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        lpi_pkg::ADDR_HYBRID_GAIN: begin
          reg_rdata <= hybrid_gain_control_reg & lpi_pkg::MASK_HYBRID_GAIN;
        end
        lpi_pkg::ADDR_PWR_OVERRIDE: begin
          reg_rdata <= power_override_control_reg;
        end
        lpi_pkg::ADDR_CONV_PWR: begin
          reg_rdata <= converter_power_control_reg;
        end
        lpi_pkg::ADDR_TIMER_PEND: begin
          reg_rdata <= 8'(timer_event_pending_reg); // [RULE12]
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Power resolution: overrides beat the automatic requests
  always_comb begin
    pwr_next.meter_dac = power_override_control_reg[lpi_pkg::PO_METER_DAC_ON]
                         | auto_pwr.meter_dac; // [RULE2]
    pwr_next.converter = ~power_override_control_reg[lpi_pkg::PO_CONV_OFF]
                         & auto_pwr.converter; // [RULE3]
    pwr_next.monitor_adc = ~power_override_control_reg[lpi_pkg::PO_MON_ADC_OFF]
                           & auto_pwr.monitor_adc; // [RULE4]
    pwr_next.bias = ~power_override_control_reg[lpi_pkg::PO_BIAS_OFF]
                    & auto_pwr.bias; // [RULE5]
    pwr_next.line_drive = ~power_override_control_reg[lpi_pkg::PO_LINE_OFF]
                          & auto_pwr.line_drive; // [RULE6]
    pwr_next.adc = converter_power_control_reg[lpi_pkg::CP_ADC_MAN]
                   ? converter_power_control_reg[lpi_pkg::CP_ADC_ON]
                   : auto_pwr.adc; // [RULE7] [RULE8]
    pwr_next.dac = converter_power_control_reg[lpi_pkg::CP_DAC_MAN]
                   ? converter_power_control_reg[lpi_pkg::CP_DAC_ON]
                   : auto_pwr.dac; // [RULE9]
    pwr_next.gm_amp = converter_power_control_reg[lpi_pkg::CP_GM_MAN]
                      ? converter_power_control_reg[lpi_pkg::CP_GM_ON]
                      : auto_pwr.gm_amp; // [RULE10]
  end

  // Registered outputs, one cycle behind register or request changes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_on <= '0;
    end else begin
      pwr_on <= pwr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meter_hybrid_gain <= lpi_pkg::RST_HYBRID_GAIN[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W];
      audio_hybrid_gain <= lpi_pkg::RST_HYBRID_GAIN[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W];
      meter_hybrid_off <= 1'b0;
      audio_hybrid_off <= 1'b0;
    end else begin
      meter_hybrid_gain <= hybrid_gain_control_reg[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W];
      audio_hybrid_gain <= hybrid_gain_control_reg[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W];
      meter_hybrid_off <= (hybrid_gain_control_reg[lpi_pkg::HYB_METER_LSB +: lpi_pkg::HYB_W]
                           == lpi_pkg::HYB_CODE_OFF); // [RULE1]
      audio_hybrid_off <= (hybrid_gain_control_reg[lpi_pkg::HYB_AUDIO_LSB +: lpi_pkg::HYB_W]
                           == lpi_pkg::HYB_CODE_OFF); // [RULE1]
    end
  end

endmodule // lpi_regs

`default_nettype wire

// ==== test/lpi_far_model.sv ====
// Far-side model: cadence timers emitting single-cycle event pulses
`default_nettype none
module lpi_far_model (
  input wire logic clk,
  input wire logic [7:0] fire,
  output logic [7:0] timer_event
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] fire_q = 8'h00;
  // Edge detect, so a request held for long still gives one pulse
  always @(posedge clk) begin
    fire_q <= fire;
    timer_event <= fire & ~fire_q;
  end
endmodule // lpi_far_model
`default_nettype wire

// ==== test/lpi_regs_asserts.sv ====
// Checker for the power and timer-event register group
`default_nettype none
module lpi_regs_asserts #(
  parameter int NUM_EVENTS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_EVENTS-1:0] timer_event,
  input wire logic [NUM_EVENTS-1:0] timer_irq_en,
  input wire logic timer_irq,
  input wire lpi_pkg::lpi_pwr_s auto_pwr,
  input wire lpi_pkg::lpi_pwr_s pwr_on,
  input wire logic [2:0] meter_hybrid_gain,
  input wire logic [2:0] audio_hybrid_gain,
  input wire logic meter_hybrid_off,
  input wire logic audio_hybrid_off
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wr_hyb, wr_ovr, wr_cp;
  logic [7:0] rmask;
  assign wr_hyb = reg_wr && reg_addr == lpi_pkg::ADDR_HYBRID_GAIN;
  assign wr_ovr = reg_wr && reg_addr == lpi_pkg::ADDR_PWR_OVERRIDE;
  assign wr_cp = reg_wr && reg_addr == lpi_pkg::ADDR_CONV_PWR;
  // Unmapped places get an all-zero mask
  assign rmask = reg_addr == lpi_pkg::ADDR_HYBRID_GAIN ? 8'h77 :
                 reg_addr == lpi_pkg::ADDR_PWR_OVERRIDE ? 8'h3B :
                 reg_addr == lpi_pkg::ADDR_CONV_PWR ? 8'h3F :
                 reg_addr == lpi_pkg::ADDR_TIMER_PEND ? 8'hFF : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_irq_raise: assert property ((timer_event & timer_irq_en) != '0 |=> timer_irq)
    else $error("irq not raised");
  a_irq_mask: assert property (timer_irq_en == '0 |=> !timer_irq)
    else $error("masked irq seen");
  a_rsvd_zero: assert property (reg_rd |=> (reg_rdata & ~$past(rmask)) == 8'h00)
    else $error("reserved bits set");
  a_hyb_off: assert property (meter_hybrid_off == (meter_hybrid_gain == 3'h7))
    else $error("hybrid off flag wrong");
  a_meter_gain: assert property (wr_hyb && reg_wdata[6:4] != 3'h6 |=> ##1
    meter_hybrid_gain == $past(reg_wdata[6:4], 2)) else $error("meter gain wrong");
  a_hyb_rsvd: assert property (wr_hyb && reg_wdata[2:0] == 3'h6 |=> ##1
    $stable(audio_hybrid_gain)) else $error("reserved code taken");
  a_meter_on: assert property (wr_ovr && reg_wdata[5] |=> ##1 pwr_on.meter_dac)
    else $error("meter dac not forced on");
  a_conv_off: assert property (wr_ovr && reg_wdata[4] |=> ##1 !pwr_on.converter)
    else $error("converter not forced off");
  a_adc_man: assert property (wr_cp && reg_wdata[5] |=> ##1
    pwr_on.adc == $past(reg_wdata[4], 2)) else $error("manual adc wrong");
  a_adc_auto: assert property (wr_cp && !reg_wdata[5] |=> ##1
    pwr_on.adc == $past(auto_pwr.adc)) else $error("automatic adc wrong");
endmodule // lpi_regs_asserts
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the power and timer-event register group
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, timer_irq;
  logic meter_hybrid_off, audio_hybrid_off;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, timer_event;
  logic [7:0] timer_irq_en = 8'h00, fire = 8'h00;
  logic [2:0] meter_hybrid_gain, audio_hybrid_gain;
  lpi_pkg::lpi_pwr_s auto_pwr = 8'h00, pwr_on;
  int mismatches = 0, total_checks = 0, cycles = 0;
  logic [7:0] pa[7] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hA5};
  logic [7:0] pr[7] = '{8'h0E, 8'h0E, 8'h0F, 8'h0F, 8'h0E, 8'h0F, 8'h0F};
  logic [7:0] pd[7] = '{8'h1B, 8'hFF, 8'hFF, 8'h2A, 8'h00, 8'h15, 8'h00};
  logic [7:0] pe[7] = '{8'h87, 8'h80, 8'h87, 8'h80, 8'hF8, 8'h00, 8'hA5};
  initial forever #12.5 clk = ~clk;
  lpi_regs u_lpi_regs (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .timer_event, .timer_irq_en, .timer_irq, .auto_pwr, .pwr_on,
    .meter_hybrid_gain, .audio_hybrid_gain, .meter_hybrid_off, .audio_hybrid_off);
  lpi_far_model u_lpi_far_model (.clk, .fire, .timer_event);
  // ==========================================================
  // Access tasks
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #2;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #2;
    reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk) #2;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #2;
    reg_rd = 0;
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic pulse(logic [7:0] b);
    @(posedge clk) #2;
    fire = b;
    @(posedge clk) #2;
    fire = 8'h00;
  endtask
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Ceiling well above the roughly 160 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    #2 sys_rst = 0;
    rd(8'h0B, 8'h00);
    rd(8'h0E, 8'h10);
    rd(8'h0F, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h77);
    chk("hyb off", 8'h03, {6'h00, meter_hybrid_off, audio_hybrid_off});
    wr(8'h0B, 8'h6D);
    rd(8'h0B, 8'h75);
    chk("hyb gains", 8'h3D, {2'h0, meter_hybrid_gain, audio_hybrid_gain});
    // Reserved code in the audio field, plain code in the meter field
    wr(8'h0B, 8'h16);
    rd(8'h0B, 8'h15);
    chk("hyb gains", 8'h0D, {2'h0, meter_hybrid_gain, audio_hybrid_gain});
    foreach (pa[i]) begin
      auto_pwr = pa[i];
      wr(pr[i], pd[i]);
      rd(pr[i], pd[i] & (pr[i] == 8'h0E ? 8'h3B : 8'h3F));
      chk("pwr_on", pe[i], pwr_on);
    end
    timer_irq_en = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h01 << i);
      chk("irq", 8'h01, {7'h00, timer_irq});
      wr(8'h12, 8'h01 << i);
      rd(8'h12, 8'h00);
      chk("irq", 8'h00, {7'h00, timer_irq});
    end
    timer_irq_en = 8'h00;
    pulse(8'h80);
    rd(8'h12, 8'h80);
    chk("masked irq", 8'h00, {7'h00, timer_irq});
    timer_irq_en = 8'h80;
    @(posedge clk) #2 fire = 8'h80;
    // Event lands at the same edge as the clearing write
    wr(8'h12, 8'h80);
    fire = 8'h00;
    rd(8'h12, 8'h80);
    chk("irq", 8'h01, {7'h00, timer_irq});
    stop_test();
  end
endmodule // testbench
bind lpi_regs lpi_regs_asserts #(.NUM_EVENTS(NUM_EVENTS)) u_lpi_regs_asserts (.clk,
  .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .timer_event,
  .timer_irq_en, .timer_irq, .auto_pwr, .pwr_on, .meter_hybrid_gain,
  .audio_hybrid_gain, .meter_hybrid_off, .audio_hybrid_off);
`default_nettype wire
